//--- verilog/sensor_cfg_params.svh
// Register offsets, field positions, reset values and timing counts of the configuration bank
// How it works
// RULE1 - Upload bit selects written offset DAC value
// RULE2 - Training word built from two-bit and byte
// RULE3 - Offset DAC code resets mid-scale, drives DAC
// RULE4 - Channel control bit zero bypasses processing
// RULE5 - Column correction only while enable bit set
// RULE6 - Substitute bit replaces samples with pattern
// RULE7 - Test pattern: two-bit upper plus byte
// RULE8 - Timing source bit: on-chip or pins
// RULE9 - Shutter bit: pipelined zero, triggered one
// RULE10 - Subsample skip: colour or monochrome pattern
// RULE11 - Continued row select held during readout
// RULE12 - Controller writes 10001 into setup field
// RULE13 - Window count codes mean one to four
// RULE14 - CRC enable bit, set after reset
// RULE15 - Column calibration only while bit set
// RULE16 - Sample count field, zero invalid
// RULE17 - Granularity: lines or scaled clock cycles
// RULE18 - Defer events outside row overhead period
// RULE19 - Multiplier equals two to exponent field
// RULE20 - Suppress pixel reset after first sample
// RULE21 - Sequencer runs at input clock over ten
// RULE22 - Controller keeps reserved fields at reset
`ifndef SENSOR_CFG_PARAMS_SVH
`define SENSOR_CFG_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_FIRST 7'h15
`define ADDR_LAST 7'h3b
`define ADDR_RESERVED_FIXED_A 7'h15
`define ADDR_RESERVED_FIXED_B 7'h16
`define ADDR_DATA_PATH_CONFIG_LOW 7'h17
`define ADDR_TRAINING_WORD_LOW 7'h18
`define ADDR_RESERVED_FIXED_C 7'h19
`define ADDR_ADC_OFFSET_DAC_CODE 7'h1a
`define ADDR_RESERVED_FIXED_D 7'h1b
`define ADDR_RESERVED_FIXED_E 7'h1c
`define ADDR_RESERVED_FIXED_F 7'h1d
`define ADDR_CHAN0_CONTROL 7'h1e
`define ADDR_CHAN0_TEST_PATTERN_LOW 7'h1f
`define ADDR_CHAN1_CONTROL 7'h20
`define ADDR_CHAN1_TEST_PATTERN_LOW 7'h21
`define ADDR_UNSHOWN_END 7'h35
`define ADDR_SYNC_CHAN_CONTROL 7'h36
`define ADDR_SYNC_CHAN_TEST_PATTERN_LOW 7'h37
`define ADDR_CAPTURE_MODE_CONTROL 7'h38
`define ADDR_SETUP_AND_WINDOW_COUNT 7'h39
`define ADDR_READOUT_OPTIONS 7'h3a
`define ADDR_TIMER_SCALE_REGISTER 7'h3b

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_RESERVED_FIXED_A 8'h20
`define RST_RESERVED_FIXED_B 8'hc0
`define RST_DATA_PATH_CONFIG_LOW 8'hc0
`define RST_TRAINING_WORD_LOW 8'h2a
`define RST_ADC_OFFSET_DAC_CODE 8'h80
`define RST_RESERVED_FIXED_D 8'h80
`define RST_CAPTURE_MODE_CONTROL 8'h02
`define RST_SETUP_AND_WINDOW_COUNT 8'h10
`define RST_READOUT_OPTIONS 8'h09
`define RST_ZERO 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_OFFSET_UPLOAD 2
`define BIT_PRBS_EN 3
`define MSB_TRAINING_HIGH 7
`define LSB_TRAINING_HIGH 6
`define BIT_CHAN_BYPASS 0
`define BIT_CHAN_FPN_EN 1
`define BIT_CHAN_SUBST 2
`define MSB_CHAN_PATTERN_HIGH 5
`define LSB_CHAN_PATTERN_HIGH 4
`define BIT_CAPTURE_EN 0
`define BIT_TIMING_MASTER 1
`define BIT_SHUTTER_TRIGGERED 2
`define BIT_SUBSAMPLE_EN 3
`define BIT_SUBSAMPLE_COLOUR 4
`define BIT_DUAL_SLOPE 5
`define BIT_TRIPLE_SLOPE 6
`define BIT_CONT_ROW_SELECT 7
`define MSB_SETUP 4
`define LSB_SETUP 0
`define MSB_WINDOW_COUNT 6
`define LSB_WINDOW_COUNT 5
`define BIT_CRC_EN 0
`define BIT_FPN_CAL_EN 2
`define MSB_SAMPLES 5
`define LSB_SAMPLES 3
`define BIT_GRAN_CLOCKS 6
`define BIT_EVENT_DEFER 7
`define MSB_TIMER_EXP 3
`define LSB_TIMER_EXP 0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SEQ_CLOCK_DIVIDE 4'd10
`define SPI_FRAME_BITS 5'd16
`define SPI_ADDR_BITS 5'd8

`endif

//--- verilog/sensor_cfg_pkg.sv
// Types shared by the sensor configuration bank
package sensor_cfg_pkg;

	// Per data channel processing settings
	typedef struct packed {
		logic bypass;
		logic fpn_en;
		logic substitute;
		logic [9:0] pattern;
	} chan_cfg_t;

	// Sequencer settings
	typedef struct packed {
		logic capture_en;
		logic timing_master;
		logic shutter_triggered;
		logic subsample_en;
		logic subsample_colour;
		logic dual_slope;
		logic triple_slope;
		logic cont_row_select;
		logic [4:0] setup;
		logic [2:0] window_count;
		logic crc_en;
		logic fpn_cal_en;
		logic [2:0] samples_per_reset;
		logic samples_invalid;
		logic gran_clocks;
		logic event_defer;
		logic [15:0] timer_multiplier;
	} seq_cfg_t;

	// Data path settings
	typedef struct packed {
		logic prbs_en;
		logic [9:0] training_word;
		logic [7:0] offset_dac;
	} data_cfg_t;

endpackage

//--- verilog/sensor_data_sequencer_config.sv
// Configuration bank with serial port, channel data path and sequencer helpers
`timescale 1ns/10ps
`include "sensor_cfg_params.svh"

module sensor_data_sequencer_config import sensor_cfg_pkg::*; #(
	parameter logic [7:0] DEFAULT_OFFSET = 8'h80,
	parameter int NCHAN = 3
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Serial configuration port
	input wire logic spi_clk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	// Channel samples
	input wire logic [NCHAN-1:0][9:0] adc_sample_i,
	output logic [NCHAN-1:0][9:0] chan_data_o,
	output chan_cfg_t [NCHAN-1:0] chan_cfg_o,
	// Integration timing
	input wire logic [2:0] internal_integration_i,
	input wire logic integration_pin_one_i,
	input wire logic integration_pin_two_i,
	input wire logic integration_pin_three_i,
	output logic [2:0] integration_o,
	// Readout helpers
	input wire logic [2:0] column_index_i,
	input wire logic row_active_i,
	input wire logic readout_active_i,
	input wire logic sample_start_i,
	input wire logic event_i,
	input wire logic row_overhead_period_i,
	output logic pixel_keep_o,
	output logic row_select_o,
	output logic pixel_reset_o,
	output logic event_o,
	output logic seq_tick_o,
	// Configuration fields
	output seq_cfg_t seq_cfg_o,
	output data_cfg_t data_cfg_o
);

	localparam int NREG = 39;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NREG-1:0][7:0] regs;
		logic [2:0] sclk_sync;
		logic [1:0] cs_sync;
		logic [1:0] mosi_sync;
		logic [5:0] pin_sync;
		logic [4:0] bit_count;
		logic [15:0] shift_in;
		logic [7:0] shift_out;
		logic miso;
		logic [3:0] div_count;
		logic seq_tick;
		logic [2:0] sample_count;
		logic pending_event;
		logic event_pulse;
		logic pixel_reset;
		logic pixel_keep;
		logic row_select;
		logic [2:0] integration;
		logic [NCHAN-1:0][9:0] chan_data;
		chan_cfg_t [NCHAN-1:0] chan_cfg;
		seq_cfg_t seq_cfg;
		data_cfg_t data_cfg;
	} state_t;

	state_t cur;
	state_t next_cur;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Mapped offsets; unshown channel entries read zero
	function automatic logic is_mapped(input logic [6:0] addr);
		is_mapped = (addr >= `ADDR_FIRST) && (addr <= `ADDR_LAST) &&
			!((addr > `ADDR_CHAN1_TEST_PATTERN_LOW) && (addr <= `ADDR_UNSHOWN_END));
	endfunction

	function automatic logic [5:0] reg_index(input logic [6:0] addr);
		logic [6:0] diff;
		diff = addr - `ADDR_FIRST;
		reg_index = diff[5:0];
	endfunction

	function automatic logic [7:0] reset_value(input logic [6:0] addr);
		case (addr)
			`ADDR_RESERVED_FIXED_A: reset_value = `RST_RESERVED_FIXED_A;
			`ADDR_RESERVED_FIXED_B: reset_value = `RST_RESERVED_FIXED_B;
			`ADDR_DATA_PATH_CONFIG_LOW: reset_value = `RST_DATA_PATH_CONFIG_LOW;
			`ADDR_TRAINING_WORD_LOW: reset_value = `RST_TRAINING_WORD_LOW;
			`ADDR_ADC_OFFSET_DAC_CODE: reset_value = `RST_ADC_OFFSET_DAC_CODE; // RULE3
			`ADDR_RESERVED_FIXED_D: reset_value = `RST_RESERVED_FIXED_D;
			`ADDR_CAPTURE_MODE_CONTROL: reset_value = `RST_CAPTURE_MODE_CONTROL; // RULE8
			`ADDR_SETUP_AND_WINDOW_COUNT: reset_value = `RST_SETUP_AND_WINDOW_COUNT;
			`ADDR_READOUT_OPTIONS: reset_value = `RST_READOUT_OPTIONS; // RULE14
			default: reset_value = `RST_ZERO; // RULE5 RULE15
		endcase
	endfunction

	// Bank reset image, fixed at elaboration so reset loads constants
	function automatic logic [NREG-1:0][7:0] reset_image();
		logic [NREG-1:0][7:0] img;
		img = '0;
		for (int i = 0; i < NREG; i++) begin
			img[i] = reset_value(`ADDR_FIRST + 7'(i));
		end
		reset_image = img;
	endfunction

	localparam logic [NREG-1:0][7:0] REG_RESET = reset_image();

	function automatic logic [7:0] reg_at(input state_t s, input logic [6:0] addr);
		reg_at = s.regs[reg_index(addr)];
	endfunction

	// Channel settings from its control and pattern registers
	function automatic chan_cfg_t chan_decode(input logic [7:0] ctrl, input logic [7:0] low);
		chan_decode.bypass = ctrl[`BIT_CHAN_BYPASS]; // RULE4
		chan_decode.fpn_en = ctrl[`BIT_CHAN_FPN_EN]; // RULE5
		chan_decode.substitute = ctrl[`BIT_CHAN_SUBST]; // RULE6
		chan_decode.pattern = {ctrl[`MSB_CHAN_PATTERN_HIGH:`LSB_CHAN_PATTERN_HIGH], low}; // RULE7
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic sclk_rise;
		logic sclk_fall;
		logic [15:0] frame;
		logic [6:0] addr;
		logic [7:0] ctrl;
		logic [7:0] seqa;
		logic [7:0] seqb;
		logic [7:0] seqc;
		logic [7:0] seqd;
		logic [7:0] dcfg;
		logic [6:0] ctrl_addr;
		logic [2:0] limit;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		frame = 16'h0000;
		addr = 7'h00;
		ctrl = 8'h00;
		seqa = 8'h00;
		seqb = 8'h00;
		seqc = 8'h00;
		seqd = 8'h00;
		dcfg = 8'h00;
		ctrl_addr = 7'h00;
		limit = 3'h0;
		next_cur = cur;

		// Edge flop gives a clean one-cycle strobe
		// Pin synchronisers; the second stage is read, and for the serial clock the third stage as well
		next_cur.sclk_sync = {cur.sclk_sync[1:0], spi_clk_i};
		next_cur.cs_sync = {cur.cs_sync[0], spi_cs_n_i};
		next_cur.mosi_sync = {cur.mosi_sync[0], spi_mosi_i};
		next_cur.pin_sync = {cur.pin_sync[2:0],
			integration_pin_three_i, integration_pin_two_i, integration_pin_one_i};
		sclk_rise = cur.sclk_sync[1] && !cur.sclk_sync[2];
		sclk_fall = !cur.sclk_sync[1] && cur.sclk_sync[2];

		// High select aborts any frame in flight
		// Serial frame: address, write flag, data byte, MSB first
		if (cur.cs_sync[1]) begin
			next_cur.bit_count = 5'd0;
		end else if (sclk_rise) begin
			frame = {cur.shift_in[14:0], cur.mosi_sync[1]};
			next_cur.shift_in = frame;
			next_cur.bit_count = cur.bit_count + 5'd1;
			if (cur.bit_count + 5'd1 == `SPI_ADDR_BITS) begin
				addr = frame[7:1];
				next_cur.shift_out = is_mapped(addr) ? reg_at(cur, addr) : 8'h00;
			end
			if (cur.bit_count + 5'd1 == `SPI_FRAME_BITS) begin
				addr = frame[15:9];
				if (frame[8] && is_mapped(addr)) begin
					next_cur.regs[reg_index(addr)] = frame[7:0];
				end
			end
		end else if (sclk_fall && (cur.bit_count >= `SPI_ADDR_BITS)) begin
			next_cur.miso = cur.shift_out[7];
			next_cur.shift_out = {cur.shift_out[6:0], 1'b0};
		end

		// Registered tick, glitch free for every user
		// Sequencer clock enable
		if (cur.div_count == `SEQ_CLOCK_DIVIDE - 4'd1) begin // RULE21
			next_cur.div_count = 4'd0;
		end else begin
			next_cur.div_count = cur.div_count + 4'd1;
		end
		next_cur.seq_tick = (cur.div_count == `SEQ_CLOCK_DIVIDE - 4'd1); // RULE21

		// Registered, so fields lag a write by a cycle
		// Field decode
		dcfg = reg_at(cur, `ADDR_DATA_PATH_CONFIG_LOW);
		seqa = reg_at(cur, `ADDR_CAPTURE_MODE_CONTROL);
		seqb = reg_at(cur, `ADDR_SETUP_AND_WINDOW_COUNT);
		seqc = reg_at(cur, `ADDR_READOUT_OPTIONS);
		seqd = reg_at(cur, `ADDR_TIMER_SCALE_REGISTER);
		next_cur.data_cfg.prbs_en = dcfg[`BIT_PRBS_EN];
		next_cur.data_cfg.training_word = {dcfg[`MSB_TRAINING_HIGH:`LSB_TRAINING_HIGH],
			reg_at(cur, `ADDR_TRAINING_WORD_LOW)}; // RULE2
		next_cur.data_cfg.offset_dac = dcfg[`BIT_OFFSET_UPLOAD] ?
			reg_at(cur, `ADDR_ADC_OFFSET_DAC_CODE) : DEFAULT_OFFSET; // RULE1 RULE3
		next_cur.seq_cfg.capture_en = seqa[`BIT_CAPTURE_EN];
		next_cur.seq_cfg.timing_master = seqa[`BIT_TIMING_MASTER]; // RULE8
		next_cur.seq_cfg.shutter_triggered = seqa[`BIT_SHUTTER_TRIGGERED]; // RULE9
		next_cur.seq_cfg.subsample_en = seqa[`BIT_SUBSAMPLE_EN];
		next_cur.seq_cfg.subsample_colour = seqa[`BIT_SUBSAMPLE_COLOUR];
		next_cur.seq_cfg.dual_slope = seqa[`BIT_DUAL_SLOPE];
		next_cur.seq_cfg.triple_slope = seqa[`BIT_TRIPLE_SLOPE];
		next_cur.seq_cfg.cont_row_select = seqa[`BIT_CONT_ROW_SELECT];
		next_cur.seq_cfg.setup = seqb[`MSB_SETUP:`LSB_SETUP]; // RULE12 RULE22
		next_cur.seq_cfg.window_count = {1'b0, seqb[`MSB_WINDOW_COUNT:`LSB_WINDOW_COUNT]} +
			3'd1; // RULE13
		next_cur.seq_cfg.crc_en = seqc[`BIT_CRC_EN]; // RULE14
		next_cur.seq_cfg.fpn_cal_en = seqc[`BIT_FPN_CAL_EN]; // RULE15
		next_cur.seq_cfg.samples_per_reset = seqc[`MSB_SAMPLES:`LSB_SAMPLES]; // RULE16
		next_cur.seq_cfg.samples_invalid = (seqc[`MSB_SAMPLES:`LSB_SAMPLES] == 3'd0); // RULE16
		next_cur.seq_cfg.gran_clocks = seqc[`BIT_GRAN_CLOCKS]; // RULE17
		next_cur.seq_cfg.event_defer = seqc[`BIT_EVENT_DEFER];
		next_cur.seq_cfg.timer_multiplier = seqc[`BIT_GRAN_CLOCKS] ?
			(16'h0001 << seqd[`MSB_TIMER_EXP:`LSB_TIMER_EXP]) : 16'h0001; // RULE17 RULE19

		// Last slot is the sync channel
		// Channel data path, updated at the sequencer rate
		for (int i = 0; i < NCHAN; i++) begin
			ctrl_addr = (i == NCHAN - 1) ? `ADDR_SYNC_CHAN_CONTROL :
				(`ADDR_CHAN0_CONTROL + 7'(2 * i));
			ctrl = reg_at(cur, ctrl_addr);
			next_cur.chan_cfg[i] = chan_decode(ctrl, reg_at(cur, ctrl_addr + 7'd1));
			if (cur.seq_tick) begin
				if (ctrl[`BIT_CHAN_SUBST]) begin
					next_cur.chan_data[i] = cur.chan_cfg[i].pattern; // RULE6
				end else begin
					next_cur.chan_data[i] = adc_sample_i[i]; // RULE4
				end
			end
		end

		// Pins lag by the synchroniser depth
		// Integration timing source
		next_cur.integration = seqa[`BIT_TIMING_MASTER] ?
			internal_integration_i : cur.pin_sync[5:3]; // RULE8

		// Subsampling keep pattern
		if (!seqa[`BIT_SUBSAMPLE_EN]) begin
			next_cur.pixel_keep = 1'b1;
		end else if (seqa[`BIT_SUBSAMPLE_COLOUR]) begin
			next_cur.pixel_keep = !column_index_i[1]; // RULE10
		end else begin
			next_cur.pixel_keep = !column_index_i[0]; // RULE10
		end

		// Row select, held through readout when continued
		next_cur.row_select = row_active_i ||
			(seqa[`BIT_CONT_ROW_SELECT] && readout_active_i); // RULE11

		// Refused zero count behaves as one
		// Pixel reset only on the first sample of each group
		limit = (seqc[`MSB_SAMPLES:`LSB_SAMPLES] == 3'd0) ? 3'd1 :
			seqc[`MSB_SAMPLES:`LSB_SAMPLES];
		next_cur.pixel_reset = 1'b0;
		if (sample_start_i) begin
			next_cur.pixel_reset = (cur.sample_count == 3'd0); // RULE20
			if (cur.sample_count + 3'd1 >= limit) begin
				next_cur.sample_count = 3'd0;
			end else begin
				next_cur.sample_count = cur.sample_count + 3'd1;
			end
		end

		// A second held event merges with the first
		// Event deferral to the next row overhead period; release beats arrival, which goes out in the same pulse
		next_cur.event_pulse = 1'b0;
		if (!seqc[`BIT_EVENT_DEFER]) begin
			next_cur.event_pulse = event_i || cur.pending_event;
			next_cur.pending_event = 1'b0;
		end else if (row_overhead_period_i) begin
			next_cur.event_pulse = event_i || cur.pending_event; // RULE18
			next_cur.pending_event = 1'b0;
		end else if (event_i) begin
			next_cur.pending_event = 1'b1; // RULE18
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur.regs <= REG_RESET;
			cur.sclk_sync <= 3'h0;
			cur.cs_sync <= 2'h3;
			cur.mosi_sync <= 2'h0;
			cur.pin_sync <= 6'h00;
			cur.bit_count <= 5'h00;
			cur.shift_in <= 16'h0000;
			cur.shift_out <= 8'h00;
			cur.miso <= 1'b0;
			cur.div_count <= 4'h0;
			cur.seq_tick <= 1'b0;
			cur.sample_count <= 3'h0;
			cur.pending_event <= 1'b0;
			cur.event_pulse <= 1'b0;
			cur.pixel_reset <= 1'b0;
			cur.pixel_keep <= 1'b1;
			cur.row_select <= 1'b0;
			cur.integration <= 3'h0;
			cur.chan_data <= '0;
			cur.chan_cfg <= '0;
			cur.seq_cfg <= '0;
			cur.data_cfg <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// No logic between flops and pins
	// Outputs straight from the state register
	assign spi_miso_o = cur.miso;
	assign chan_data_o = cur.chan_data;
	assign chan_cfg_o = cur.chan_cfg;
	assign integration_o = cur.integration;
	assign pixel_keep_o = cur.pixel_keep;
	assign row_select_o = cur.row_select;
	assign pixel_reset_o = cur.pixel_reset;
	assign event_o = cur.event_pulse;
	assign seq_tick_o = cur.seq_tick;
	assign seq_cfg_o = cur.seq_cfg;
	assign data_cfg_o = cur.data_cfg;

endmodule

//--- verification/cfg_bank_chk.sv
// Port assertions for the sensor configuration bank
`timescale 1ns/10ps
module cfg_bank_chk import sensor_cfg_pkg::*; #(
	parameter int NCHAN = 3
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Channel path
	input wire logic [NCHAN-1:0][9:0] chan_data_o,
	input wire chan_cfg_t [NCHAN-1:0] chan_cfg_o,
	input wire logic seq_tick_o,
	// Integration timing
	input wire logic [2:0] internal_integration_i,
	input wire logic [2:0] integration_o,
	// Readout helpers
	input wire logic [2:0] column_index_i,
	input wire logic row_active_i,
	input wire logic readout_active_i,
	input wire logic sample_start_i,
	input wire logic event_i,
	input wire logic row_overhead_period_i,
	input wire logic pixel_keep_o,
	input wire logic row_select_o,
	input wire logic pixel_reset_o,
	input wire logic event_o,
	// Decoded fields
	input wire seq_cfg_t seq_cfg_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [2:0] up;
	logic ok;
	// Cycles since reset release, so decodes are valid
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			up <= 3'h0;
		else if (up != 3'h4)
			up <= up + 3'h1;
	end
	assign ok = (up == 3'h4);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence held_event;
		event_i && !row_overhead_period_i ##1 seq_cfg_o.event_defer;
	endsequence
	sequence direct_event;
		event_i && !seq_cfg_o.event_defer ##1 !seq_cfg_o.event_defer;
	endsequence
	sequence subst_tick;
		seq_tick_o && chan_cfg_o[0].substitute ##1 chan_cfg_o[0].substitute
			##1 chan_cfg_o[0].substitute;
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_tick_gap: assert property (seq_tick_o |=> !seq_tick_o [*8])
		else $error("tick came early");
	a_tick_period: assert property (seq_tick_o |-> ##10 seq_tick_o)
		else $error("tick period wrong");
	a_master_timing: assert property (seq_cfg_o.timing_master
		&& $past(seq_cfg_o.timing_master) |-> integration_o == $past(internal_integration_i))
		else $error("integration not on-chip");
	a_cont_row: assert property (ok && $stable(seq_cfg_o.cont_row_select)
		|-> row_select_o ==
		$past(row_active_i | (seq_cfg_o.cont_row_select & readout_active_i)))
		else $error("row select wrong");
	a_keep_pattern: assert property (ok && $stable(seq_cfg_o.subsample_en)
		&& $stable(seq_cfg_o.subsample_colour) |-> pixel_keep_o == $past(!seq_cfg_o.subsample_en
		|| (seq_cfg_o.subsample_colour ? !column_index_i[1] : !column_index_i[0])))
		else $error("subsample keep wrong");
	a_reset_cause: assert property (pixel_reset_o |-> $past(sample_start_i))
		else $error("pixel reset without start");
	a_reset_single: assert property (pixel_reset_o |=> !pixel_reset_o)
		else $error("pixel reset too long");
	a_event_direct: assert property (direct_event |-> event_o)
		else $error("event not passed");
	a_event_held: assert property (held_event |-> !event_o)
		else $error("event not deferred");
	a_subst_data: assert property (subst_tick |-> chan_data_o[0] ==
		$past(chan_cfg_o[0].pattern))
		else $error("test pattern not substituted");
	a_mult_one: assert property (ok && !seq_cfg_o.gran_clocks
		|-> seq_cfg_o.timer_multiplier == 16'h0001)
		else $error("line mode multiplier");
	a_mult_pow: assert property (ok && seq_cfg_o.gran_clocks
		|-> $onehot(seq_cfg_o.timer_multiplier))
		else $error("multiplier not power of two");
	a_window_range: assert property (ok |-> seq_cfg_o.window_count inside {[3'h1:3'h4]})
		else $error("window count out of range");
endmodule

bind sensor_data_sequencer_config cfg_bank_chk #(.NCHAN(NCHAN)) chk_u (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .chan_data_o(chan_data_o),
	.chan_cfg_o(chan_cfg_o), .seq_tick_o(seq_tick_o),
	.internal_integration_i(internal_integration_i), .integration_o(integration_o),
	.column_index_i(column_index_i), .row_active_i(row_active_i),
	.readout_active_i(readout_active_i), .sample_start_i(sample_start_i),
	.event_i(event_i), .row_overhead_period_i(row_overhead_period_i),
	.pixel_keep_o(pixel_keep_o), .row_select_o(row_select_o),
	.pixel_reset_o(pixel_reset_o), .event_o(event_o), .seq_cfg_o(seq_cfg_o)
);

//--- verification/cam_ctrl_model.sv
// Camera controller model on the serial configuration port
`timescale 1ns/10ps
module cam_ctrl_model (
	// Clock
	input wire logic mclk_i,
	// Serial port
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// Idle levels
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Whole cycles, then just past the edge
	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// One 16-bit frame; six-cycle phases clear the synchroniser
	task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [15:0] frame;
		frame = {addr, wr, wdata};
		rdata = 8'h00;
		wait_clk(1);
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = frame[i];
			wait_clk(6);
			if (i < 8)
				rdata[i] = miso_i;
			sclk_o = 1'b1;
			wait_clk(6);
			sclk_o = 1'b0;
		end
		wait_clk(6);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line does not keep old bit
		wait_clk(4);
	endtask
endmodule

//--- verification/tb_top.sv
// Self-checking testbench of the sensor configuration bank
`timescale 1ns/10ps
module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic sclk, cs_n, mosi, miso;
	logic [2:0][9:0] adc = '0;
	logic [2:0][9:0] chan_data;
	sensor_cfg_pkg::chan_cfg_t [2:0] chan_cfg;
	sensor_cfg_pkg::seq_cfg_t seq;
	sensor_cfg_pkg::data_cfg_t dat;
	logic [2:0] int_int = 3'h2;
	logic [2:0] int_out;
	logic [2:0] col = 3'h0;
	logic pin1 = 0, pin2 = 0, pin3 = 0, row_act = 0, rd_act = 0, smp = 0, evt = 0, row_overhead_period = 0;
	logic keep, rsel, prst, evt_o, tick;
	logic [7:0] rd;
	int err_total = 0, checks_done = 0, cyc = 0, n_evt = 0, n_rst = 0, n_tick = 0, t0;
	logic [6:0] ra [17] = '{7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1e, 7'h1f,
		7'h20, 7'h21, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3a, 7'h22};
	logic [7:0] rv [17] = '{8'h20, 8'hc0, 8'hc0, 8'h2a, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h10, 8'h09, 8'h00};

	always #20 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	sensor_data_sequencer_config #(.NCHAN(3)) dut_u (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .spi_clk_i(sclk), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .adc_sample_i(adc), .chan_data_o(chan_data),
		.chan_cfg_o(chan_cfg), .internal_integration_i(int_int),
		.integration_pin_one_i(pin1), .integration_pin_two_i(pin2),
		.integration_pin_three_i(pin3), .integration_o(int_out), .column_index_i(col),
		.row_active_i(row_act), .readout_active_i(rd_act), .sample_start_i(smp),
		.event_i(evt), .row_overhead_period_i(row_overhead_period), .pixel_keep_o(keep),
		.row_select_o(rsel), .pixel_reset_o(prst), .event_o(evt_o), .seq_tick_o(tick),
		.seq_cfg_o(seq), .data_cfg_o(dat));
	cam_ctrl_model ctrl_u (.mclk_i(mclk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso));

	// Pulse counters and hang limit
	always @(posedge mclk_i) begin
		cyc++;
		if (evt_o === 1'b1)
			n_evt++;
		if (prst === 1'b1)
			n_rst++;
		if (tick === 1'b1)
			n_tick++;
		if (cyc == 30000) begin
			err_total++;
			results();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic clk(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		ctrl_u.xfer(a, 1'b1, d, rd);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		ctrl_u.xfer(a, 1'b0, 8'h00, rd);
		check("register", {24'h0, e}, {24'h0, rd});
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk(16);
		reset_n_i = 1'b1;
		clk(4);
		for (int i = 0; i < 17; i++)
			rd_chk(ra[i], rv[i]);
		check("training", 32'h32a, dat.training_word);
		check("offset", 32'h80, dat.offset_dac);
		// Unmapped place ignores writes
		wr(7'h22, 8'hff);
		rd_chk(7'h22, 8'h00);
		// Setup value, then every window code
		for (int c = 0; c < 4; c++) begin
			wr(7'h39, {1'b0, c[1:0], 5'h11});
			check("windows", c + 1, seq.window_count);
		end
		check("setup", 32'h11, seq.setup);
		// Offset upload and training word
		wr(7'h1a, 8'h5c);
		check("offset", 32'h80, dat.offset_dac);
		wr(7'h17, 8'h4c);
		wr(7'h18, 8'h3c);
		check("offset", 32'h5c, dat.offset_dac);
		check("training", 32'h13c, dat.training_word);
		check("prbs", 32'h1, dat.prbs_en);
		// Channel controls and test substitution
		adc = {10'h0aa, 10'h155, 10'h3c3};
		wr(7'h1f, 8'h9d);
		wr(7'h1e, 8'h27);
		wr(7'h36, 8'h02);
		check("chan0 cfg", 32'h1e9d, chan_cfg[0]);
		check("chan1 cfg", 32'h0, chan_cfg[1]);
		check("sync cfg", 32'h800, chan_cfg[2]);
		clk(25);
		check("chan0 data", 32'h29d, chan_data[0]);
		check("chan1 data", 32'h155, chan_data[1]);
		wr(7'h1e, 8'h01);
		clk(25);
		check("chan0 data", 32'h3c3, chan_data[0]);
		// Slave timing, shutter, subsampling, row select
		{pin3, pin2, pin1} = 3'b101;
		rd_act = 1'b1;
		for (int m = 0; m < 2; m++) begin
			wr(7'h38, m ? 8'hed : 8'hfd);
			check("mode", m ? 32'hb7 : 32'hbf, seq[39:32]);
			for (int i = 0; i < 8; i++) begin
				col = i[2:0];
				clk(2);
				check("keep", {31'h0, m ? ~col[0] : ~col[1]}, keep);
			end
		end
		check("shutter", 32'h1, seq.shutter_triggered);
		check("integration", 32'h5, int_out);
		check("row select", 32'h1, rsel);
		wr(7'h38, 8'h02);
		check("mode", 32'h40, seq[39:32]);
		rd_act = 1'b0;
		int_int = 3'h6;
		clk(2);
		check("shutter", 32'h0, seq.shutter_triggered);
		check("integration", 32'h6, int_out);
		check("row select", 32'h0, rsel);
		// Readout options and timer scale
		wr(7'h3a, 8'hd5);
		wr(7'h3b, 8'h05);
		check("crc cal", 32'h3, {seq.crc_en, seq.fpn_cal_en});
		check("samples", 32'h2, seq.samples_per_reset);
		check("multiplier", 32'h20, seq.timer_multiplier);
		// Deferred event waits for the overhead period
		evt = 1'b1;
		clk(1);
		evt = 1'b0;
		clk(5);
		check("deferred", 32'h0, n_evt);
		row_overhead_period = 1'b1;
		clk(3);
		row_overhead_period = 1'b0;
		check("released", 32'h1, n_evt);
		// Two samples per reset
		repeat (4) begin
			smp = 1'b1;
			clk(1);
			smp = 1'b0;
			clk(3);
		end
		check("pixel resets", 32'h2, n_rst);
		// All options off, invalid sample code
		wr(7'h3a, 8'h00);
		check("crc cal", 32'h0, {seq.crc_en, seq.fpn_cal_en});
		check("invalid", 32'h1, seq.samples_invalid);
		check("multiplier", 32'h1, seq.timer_multiplier);
		evt = 1'b1;
		clk(1);
		evt = 1'b0;
		clk(3);
		check("direct", 32'h2, n_evt);
		// Sequencer tick rate
		t0 = n_tick;
		clk(100);
		check("ticks", 32'd10, n_tick - t0);
		results();
	end
endmodule
